// ### inc/cgc_pkg.sv
package cgc_pkg;

    // bus-side constants
    localparam logic [6:0] CGC_SLAVE_ADDR  = 7'h69;
    localparam int         CGC_NUM_BYTES   = 15;
    localparam logic [3:0] CGC_BIT_DONE    = 4'h8;
    localparam logic [3:0] CGC_BIT_LAST    = 4'h7;

    // register offsets
    localparam logic [6:0] CGC_OFS_POWERDOWN_RETENTION = 7'h00;
    localparam logic [6:0] CGC_OFS_SPREAD_PROFILE      = 7'h01;
    localparam logic [6:0] CGC_OFS_RESERVED_TWO        = 7'h02;
    localparam logic [6:0] CGC_OFS_RESERVED_THREE      = 7'h03;
    localparam logic [6:0] CGC_OFS_OUTPUT_ENABLE       = 7'h04;
    localparam logic [6:0] CGC_OFS_RESERVED_FIVE       = 7'h05;
    localparam logic [6:0] CGC_OFS_RESERVED_SIX        = 7'h06;
    localparam logic [6:0] CGC_OFS_MAKER_REVISION      = 7'h07;
    localparam logic [6:0] CGC_OFS_PART_IDENT          = 7'h08;
    localparam logic [6:0] CGC_OFS_TEST_AMPLITUDE      = 7'h09;
    localparam logic [6:0] CGC_OFS_RESERVED_TEN        = 7'h0A;
    localparam logic [6:0] CGC_OFS_RESERVED_ELEVEN     = 7'h0B;
    localparam logic [6:0] CGC_OFS_BYTE_COUNT          = 7'h0C;
    localparam logic [6:0] CGC_OFS_RESERVED_THIRTEEN   = 7'h0D;
    localparam logic [6:0] CGC_OFS_PROGRAM_IDENT       = 7'h0E;

    // field positions
    localparam int CGC_POS_POWERDOWN_KEEP_CONFIG  = 0;
    localparam int CGC_POS_SPREAD_CENTER_SELECT   = 6;
    localparam int CGC_POS_REF_OUT0_ENABLE        = 6;
    localparam int CGC_POS_REF_OUT1_ENABLE        = 5;
    localparam int CGC_POS_REF_OUT3_ENABLE        = 3;
    localparam int CGC_POS_REF_OUT2_ENABLE        = 2;
    localparam int CGC_POS_SPREAD_MODULATION_EN   = 1;
    localparam int CGC_POS_TEST_MODE_SELECT       = 4;
    localparam int CGC_POS_TEST_MODE_ENTRY        = 3;
    localparam int CGC_POS_AMPLITUDE_CODE         = 0;

    // power-up values, then the fill for reads past the block count or the bank
    localparam logic [7:0] CGC_RST_POWERDOWN_RETENTION = 8'hA1;
    localparam logic [7:0] CGC_RST_SPREAD_PROFILE      = 8'h85;
    localparam logic [7:0] CGC_RST_RESERVED_TWO        = 8'h3F;
    localparam logic [7:0] CGC_RST_RESERVED_THREE      = 8'hFF;
    localparam logic [7:0] CGC_RST_OUTPUT_ENABLE       = 8'hED;
    localparam logic [7:0] CGC_RST_RESERVED_FIVE       = 8'h00;
    localparam logic [7:0] CGC_RST_RESERVED_SIX        = 8'h00;
    localparam logic [7:0] CGC_RST_TEST_AMPLITUDE      = 8'h25;
    localparam logic [7:0] CGC_RST_RESERVED_TEN        = 8'h03;
    localparam logic [7:0] CGC_RST_RESERVED_ELEVEN     = 8'h07;
    localparam logic [7:0] CGC_RST_BYTE_COUNT          = 8'h0F;
    localparam logic [7:0] CGC_RST_RESERVED_THIRTEEN   = 8'hFC;
    localparam logic [7:0] CGC_READ_PAST_COUNT         = 8'hFF;
    localparam logic [7:0] CGC_READ_UNMAPPED           = 8'h00;

    // software-writable bits per byte
    localparam logic [7:0] CGC_WMASK_POWERDOWN_RETENTION = 8'h01;
    localparam logic [7:0] CGC_WMASK_SPREAD_PROFILE      = 8'h40;
    localparam logic [7:0] CGC_WMASK_OUTPUT_ENABLE       = 8'h6E;
    localparam logic [7:0] CGC_WMASK_TEST_AMPLITUDE      = 8'h1F;
    localparam logic [7:0] CGC_WMASK_BYTE_COUNT          = 8'hFF;
    localparam logic [7:0] CGC_WMASK_NONE                = 8'h00;

    typedef enum logic [2:0] {
        CGC_ST_IDLE,
        CGC_ST_ADDR,
        CGC_ST_CMD,
        CGC_ST_WDATA,
        CGC_ST_ACK,
        CGC_ST_RDATA,
        CGC_ST_RACK,
        CGC_ST_WAIT
    } cgc_state_t;

    typedef struct packed {
        cgc_state_t state;
        cgc_state_t after;
        logic [7:0] shift;
        logic [3:0] bitcnt;
        logic [6:0] ptr;
        logic [7:0] cnt;
        logic       block;
        logic       first;
        logic       sda_oe_n;
    } cgc_smb_t;

    typedef struct packed {
        logic [3:0] ref_out_enable;
        logic       spread_modulation_enable;
        logic       spread_center_select;
        logic       test_mode_entry;
        logic       outputs_tristate;
        logic       outputs_ref_div;
        logic [2:0] amplitude_code;
    } cgc_ctrl_t;

    function automatic logic [7:0] cgc_wmask(input logic [6:0] idx);
        case (idx)
            CGC_OFS_POWERDOWN_RETENTION: cgc_wmask = CGC_WMASK_POWERDOWN_RETENTION;
            CGC_OFS_SPREAD_PROFILE:      cgc_wmask = CGC_WMASK_SPREAD_PROFILE;
            CGC_OFS_OUTPUT_ENABLE:       cgc_wmask = CGC_WMASK_OUTPUT_ENABLE;
            CGC_OFS_TEST_AMPLITUDE:      cgc_wmask = CGC_WMASK_TEST_AMPLITUDE;
            CGC_OFS_BYTE_COUNT:          cgc_wmask = CGC_WMASK_BYTE_COUNT;
            default:                     cgc_wmask = CGC_WMASK_NONE;
        endcase
    endfunction

endpackage

// ### core/cgc_config_bank.sv
`timescale 1ns/1ps
// How it works
// - byte 0 bit 0 keeps configuration over power-down; zero clears it to defaults.
// - byte 1 bit 6 picks down spread (0) or center spread (1).
// - byte 4 bits 6,5,2,3 enable outputs 0,1,2,3; one enables.
// - byte 4 bit 1 turns spread modulation on with the chosen profile.
// - byte 9 bit 3 puts the device into test mode.
// - in test mode byte 9 bit 4 picks tri-state (0) or reference/N (1).
// - byte 9 bits 2:0 set amplitude 0.30V..1.00V, default 101.
// - every register takes its default at power-up before any serial access.
// - command bit 7 low means block access, high means byte access at bits 6:0.
// - the slave answers at write address 11010010.
// - block read returns as many bytes as the byte-count register holds.
module cgc_config_bank
    import cgc_pkg::*;
#(
    parameter logic [3:0] REV_CODE    = 4'h3,  // arbitrary value
    parameter logic [3:0] VENDOR_CODE = 4'h5,  // arbitrary value
    parameter logic [3:0] PART_CODE   = 4'h6,  // arbitrary value
    parameter logic [7:0] PROG_CODE   = 8'h5A  // arbitrary value
)(
    input  wire logic       sys_clk_i,
    input  wire logic       resetn_i,
    input  wire logic       ce_i,
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe_n_o,
    input  wire logic       powerdown_n_i,
    output cgc_ctrl_t       ctrl_o
);

    if (CGC_NUM_BYTES > 16) begin : g_bad_size
        $error("register file index is only four bits wide");
    end

    if (CGC_NUM_BYTES <= int'(CGC_OFS_BYTE_COUNT)) begin : g_no_count
        $error("bank must reach the byte-count register");
    end

    if (int'(CGC_BIT_LAST) + 1 != int'(CGC_BIT_DONE)) begin : g_bad_bits
        $error("bit counter end points disagree");
    end

    if (CGC_POS_AMPLITUDE_CODE > 5) begin : g_bad_amp
        $error("amplitude field runs past bit 7");
    end

    cgc_smb_t   smb_r;
    cgc_smb_t   smb_nxt;
    cgc_ctrl_t  ctrl_r;
    cgc_ctrl_t  ctrl_nxt;
    logic [7:0] cfg_r [CGC_NUM_BYTES];
    logic       scl_q_r;
    logic       sda_q_r;
    logic       pd_q_r;
    logic       sda_lo_r;
    logic       wr_en;
    logic       do_load;

    function automatic logic [7:0] def_byte(input logic [6:0] idx);
        case (idx)
            CGC_OFS_POWERDOWN_RETENTION: def_byte = CGC_RST_POWERDOWN_RETENTION;
            CGC_OFS_SPREAD_PROFILE:      def_byte = CGC_RST_SPREAD_PROFILE;
            CGC_OFS_RESERVED_TWO:        def_byte = CGC_RST_RESERVED_TWO;
            CGC_OFS_RESERVED_THREE:      def_byte = CGC_RST_RESERVED_THREE;
            CGC_OFS_OUTPUT_ENABLE:       def_byte = CGC_RST_OUTPUT_ENABLE;
            CGC_OFS_RESERVED_FIVE:       def_byte = CGC_RST_RESERVED_FIVE;
            CGC_OFS_RESERVED_SIX:        def_byte = CGC_RST_RESERVED_SIX;
            CGC_OFS_MAKER_REVISION:      def_byte = {REV_CODE, VENDOR_CODE};
            CGC_OFS_PART_IDENT:          def_byte = {PART_CODE, 4'h0};
            CGC_OFS_TEST_AMPLITUDE:      def_byte = CGC_RST_TEST_AMPLITUDE;
            CGC_OFS_RESERVED_TEN:        def_byte = CGC_RST_RESERVED_TEN;
            CGC_OFS_RESERVED_ELEVEN:     def_byte = CGC_RST_RESERVED_ELEVEN;
            CGC_OFS_BYTE_COUNT:          def_byte = CGC_RST_BYTE_COUNT;
            CGC_OFS_RESERVED_THIRTEEN:   def_byte = CGC_RST_RESERVED_THIRTEEN;
            CGC_OFS_PROGRAM_IDENT:       def_byte = PROG_CODE;
            default:                     def_byte = CGC_READ_UNMAPPED;
        endcase
    endfunction

    // bus line events; pins are already synchronous to sys_clk_i
    wire scl_rise   = scl_i & ~scl_q_r;
    wire scl_fall   = ~scl_i & scl_q_r;
    wire bus_start  = scl_i & scl_q_r & sda_q_r & ~sda_i;
    wire bus_stop   = scl_i & scl_q_r & ~sda_q_r & sda_i;
    wire byte_in    = (smb_r.bitcnt == CGC_BIT_DONE);
    wire ptr_mapped = (smb_r.ptr < 7'(CGC_NUM_BYTES));

    // offsets past the bank read as zero and swallow writes
    wire [7:0] byte_count = cfg_r[CGC_OFS_BYTE_COUNT[3:0]];
    wire [7:0] ptr_byte   = ptr_mapped ? cfg_r[smb_r.ptr[3:0]] : CGC_READ_UNMAPPED;
    wire       count_slot = smb_r.block & smb_r.first;
    wire [7:0] rd_byte    = count_slot                         ? byte_count :
                            (smb_r.block && smb_r.cnt == 8'h00) ? CGC_READ_PAST_COUNT :
                            ptr_byte;

    // only the writable bits change; reserved and identity bits hold their values
    wire [7:0] wr_mask = cgc_wmask(smb_r.ptr);
    wire [7:0] wr_val  = (smb_r.shift & wr_mask) | (ptr_byte & ~wr_mask);
    wire       keep_cfg = cfg_r[CGC_OFS_POWERDOWN_RETENTION[3:0]][CGC_POS_POWERDOWN_KEEP_CONFIG];
    wire       pd_clear = pd_q_r & ~powerdown_n_i & ~keep_cfg;

    // start and stop outrank bit events, so a restart mid-byte always resyncs
    always_comb begin
        smb_nxt = smb_r;
        wr_en   = 1'b0;
        do_load = 1'b0;
        if (bus_start) begin
            smb_nxt.state    = CGC_ST_ADDR;
            smb_nxt.bitcnt   = 4'h0;
            smb_nxt.sda_oe_n = 1'b1;
        end else if (bus_stop) begin
            smb_nxt.state    = CGC_ST_IDLE;
            smb_nxt.sda_oe_n = 1'b1;
        end else if (scl_rise) begin
            case (smb_r.state)
                CGC_ST_ADDR, CGC_ST_CMD, CGC_ST_WDATA: begin
                    smb_nxt.shift  = {smb_r.shift[6:0], sda_i};
                    smb_nxt.bitcnt = smb_r.bitcnt + 4'h1;
                end
                CGC_ST_RACK: begin
                    // not-acknowledge ends the read; wait for stop or restart
                    if (sda_i) begin
                        smb_nxt.state = CGC_ST_WAIT;
                    end
                end
                default: ;
            endcase
        end else if (scl_fall) begin
            case (smb_r.state)
                CGC_ST_ADDR: begin
                    if (byte_in) begin
                        if (smb_r.shift[7:1] == CGC_SLAVE_ADDR) begin
                            smb_nxt.state    = CGC_ST_ACK;
                            smb_nxt.sda_oe_n = 1'b0;
                            smb_nxt.after    = smb_r.shift[0] ? CGC_ST_RDATA : CGC_ST_CMD;
                        end else begin
                            smb_nxt.state = CGC_ST_WAIT;
                        end
                    end
                end
                CGC_ST_CMD: begin
                    if (byte_in) begin
                        smb_nxt.state    = CGC_ST_ACK;
                        smb_nxt.sda_oe_n = 1'b0;
                        smb_nxt.after    = CGC_ST_WDATA;
                        smb_nxt.block    = ~smb_r.shift[7];
                        smb_nxt.ptr      = smb_r.shift[7] ? smb_r.shift[6:0] : 7'h00;
                        smb_nxt.first    = 1'b1;
                    end
                end
                CGC_ST_WDATA: begin
                    if (byte_in) begin
                        smb_nxt.state    = CGC_ST_ACK;
                        smb_nxt.sda_oe_n = 1'b0;
                        smb_nxt.after    = CGC_ST_WDATA;
                        if (count_slot) begin
                            // first byte of a block write is the controller's count
                            smb_nxt.first = 1'b0;
                        end else begin
                            wr_en = ptr_mapped;
                            if (smb_r.block) begin
                                smb_nxt.ptr = smb_r.ptr + 7'h01;
                            end
                        end
                    end
                end
                CGC_ST_ACK: begin
                    smb_nxt.bitcnt = 4'h0;
                    if (smb_r.after == CGC_ST_RDATA) begin
                        do_load = 1'b1;
                    end else begin
                        smb_nxt.state    = smb_r.after;
                        smb_nxt.sda_oe_n = 1'b1;
                    end
                end
                CGC_ST_RDATA: begin
                    smb_nxt.bitcnt = smb_r.bitcnt + 4'h1;
                    if (smb_r.bitcnt == CGC_BIT_LAST) begin
                        smb_nxt.state    = CGC_ST_RACK;
                        smb_nxt.sda_oe_n = 1'b1;
                    end else begin
                        // next bit leaves one clock after the fall, early in scl low
                        smb_nxt.shift    = {smb_r.shift[6:0], 1'b1};
                        smb_nxt.sda_oe_n = smb_r.shift[6];
                    end
                end
                CGC_ST_RACK: begin
                    do_load = 1'b1;
                end
                default: ;
            endcase
        end
        if (do_load) begin
            smb_nxt.state    = CGC_ST_RDATA;
            smb_nxt.bitcnt   = 4'h0;
            smb_nxt.shift    = rd_byte;
            smb_nxt.sda_oe_n = rd_byte[7];
            if (count_slot) begin
                smb_nxt.cnt   = byte_count;
                smb_nxt.first = 1'b0;
            end else if (smb_r.block) begin
                smb_nxt.ptr = smb_r.ptr + 7'h01;
                if (smb_r.cnt != 8'h00) begin
                    smb_nxt.cnt = smb_r.cnt - 8'h01;
                end
            end
        end
    end

    // one decode serves the live outputs and their reset value alike
    function automatic cgc_ctrl_t ctrl_decode(input logic [7:0] oe_b,
                                              input logic [7:0] sprd_b,
                                              input logic [7:0] test_b);
        cgc_ctrl_t c;
        logic      entry;
        logic      sel;
        entry = test_b[CGC_POS_TEST_MODE_ENTRY];
        sel   = test_b[CGC_POS_TEST_MODE_SELECT];
        c.ref_out_enable = {oe_b[CGC_POS_REF_OUT3_ENABLE],
                            oe_b[CGC_POS_REF_OUT2_ENABLE],
                            oe_b[CGC_POS_REF_OUT1_ENABLE],
                            oe_b[CGC_POS_REF_OUT0_ENABLE]};
        c.spread_modulation_enable = oe_b[CGC_POS_SPREAD_MODULATION_EN];
        c.spread_center_select     = sprd_b[CGC_POS_SPREAD_CENTER_SELECT];
        c.test_mode_entry          = entry;
        c.outputs_tristate         = entry & ~sel;
        c.outputs_ref_div          = entry & sel;
        c.amplitude_code           = test_b[CGC_POS_AMPLITUDE_CODE +: 3];
        return c;
    endfunction

    localparam cgc_ctrl_t CTRL_RESET = ctrl_decode(CGC_RST_OUTPUT_ENABLE,
                                                   CGC_RST_SPREAD_PROFILE,
                                                   CGC_RST_TEST_AMPLITUDE);

    // live control bytes
    wire [7:0] oe_byte   = cfg_r[CGC_OFS_OUTPUT_ENABLE[3:0]];
    wire [7:0] sprd_byte = cfg_r[CGC_OFS_SPREAD_PROFILE[3:0]];
    wire [7:0] test_byte = cfg_r[CGC_OFS_TEST_AMPLITUDE[3:0]];
    assign ctrl_nxt = ctrl_decode(oe_byte, sprd_byte, test_byte);

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            for (int i = 0; i < CGC_NUM_BYTES; i++) begin
                cfg_r[i] <= def_byte(7'(i));
            end
        end else if (ce_i) begin
            // a clear outranks a write landing in the same cycle
            if (pd_clear) begin
                for (int i = 0; i < CGC_NUM_BYTES; i++) begin
                    cfg_r[i] <= def_byte(7'(i));
                end
            end else if (wr_en) begin
                cfg_r[smb_r.ptr[3:0]] <= wr_val;
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            smb_r    <= '{state: CGC_ST_IDLE, after: CGC_ST_IDLE, shift: 8'h00,
                          bitcnt: 4'h0, ptr: 7'h00, cnt: 8'h00, block: 1'b0,
                          first: 1'b0, sda_oe_n: 1'b1};
            scl_q_r  <= 1'b1;
            sda_q_r  <= 1'b1;
            pd_q_r   <= 1'b1;
            sda_lo_r <= 1'b0;
        end else if (ce_i) begin
            // edge detectors freeze with ce_i too, so no edge is doubled; a pulse that ends while ce_i is low is lost
            smb_r    <= smb_nxt;
            scl_q_r  <= scl_i;
            sda_q_r  <= sda_i;
            pd_q_r   <= powerdown_n_i;
            sda_lo_r <= 1'b0;
        end
    end

    // outputs lag the register file by one cycle so they leave from flops
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ctrl_r <= CTRL_RESET;
        end else if (ce_i) begin
            ctrl_r <= ctrl_nxt;
        end
    end

    // open drain: only ever pulls low
    assign sda_o      = sda_lo_r;
    assign sda_oe_n_o = smb_r.sda_oe_n;
    assign ctrl_o     = ctrl_r;

endmodule

// ### verification/cgc_config_bank_assertions.sv
`timescale 1ns/1ps
module cgc_config_bank_assertions
    import cgc_pkg::*;
(
    input wire logic      sys_clk_i,
    input wire logic      resetn_i,
    input wire logic      ce_i,
    input wire logic      scl_i,
    input wire logic      sda_i,
    input wire logic      sda_o,
    input wire logic      sda_oe_n_o,
    input wire logic      powerdown_n_i,
    input wire cgc_ctrl_t ctrl_o
);
    localparam logic [11:0] CTRL_DEFAULT = 12'hF05;
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!resetn_i);
    // the drive flop may sit one or two edges behind the sampled fall
    sequence scl_just_fell;
        !$past(scl_i) && ($past(scl_i, 2) || $past(scl_i, 3));
    endsequence
    sequence pd_fall;
        powerdown_n_i ##1 !powerdown_n_i;
    endsequence
    chk_sda_pull_only: assert property (sda_o == 1'b0)
        else $error("sda data output is not low");
    chk_ack_start: assert property ($fell(sda_oe_n_o) |-> scl_just_fell)
        else $error("sda drive began away from an scl fall");
    chk_ack_release: assert property ($rose(sda_oe_n_o) |-> scl_just_fell)
        else $error("sda drive ended away from an scl fall");
    chk_hold_scl_high: assert property (scl_i && $past(scl_i) |-> $stable(sda_oe_n_o))
        else $error("sda drive changed while scl high");
    // settings move only on an acked byte or a power-down fall
    chk_ctrl_cause: assert property (!$stable(ctrl_o) |->
        !sda_oe_n_o || (!$past(powerdown_n_i, 2) && $past(powerdown_n_i, 3)))
        else $error("control outputs changed without cause");
    chk_pd_reload: assert property (pd_fall |-> ##2
        ($stable(ctrl_o) || ctrl_o == CTRL_DEFAULT))
        else $error("power-down left a partial configuration");
    chk_test_select: assert property (ctrl_o.test_mode_entry |->
        (ctrl_o.outputs_tristate ^ ctrl_o.outputs_ref_div))
        else $error("test mode output choice not exclusive");
    chk_test_normal: assert property (!ctrl_o.test_mode_entry |->
        !(ctrl_o.outputs_tristate || ctrl_o.outputs_ref_div))
        else $error("test output mode outside test mode");
    chk_ce_freeze: assert property (!ce_i |=> $stable(ctrl_o) && $stable(sda_oe_n_o))
        else $error("state moved while the clock enable was low");
endmodule
bind cgc_config_bank cgc_config_bank_assertions i_cgc_config_bank_assertions (
    .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .ce_i(ce_i), .scl_i(scl_i),
    .sda_i(sda_i), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o),
    .powerdown_n_i(powerdown_n_i), .ctrl_o(ctrl_o)
);

// ### verification/cgc_smb_host.sv
`timescale 1ns/1ps
// smbus controller; scl stands high between frames, sda released as 1
module cgc_smb_host (
    input  wire logic sys_clk_i,
    input  wire logic sda_i,
    output logic      scl_o = 1'b1,
    output logic      sda_o = 1'b1
);
    task automatic phase(input logic c, input logic d, input int n);
        scl_o <= c;
        sda_o <= d;
        repeat (n) @(posedge sys_clk_i);
    endtask
    // also a repeated start when scl is low
    task automatic start();
        phase(scl_o, 1'b1, 4);
        phase(1'b1, 1'b1, 4);
        phase(1'b1, 1'b0, 4);
        phase(1'b0, 1'b0, 4);
    endtask
    task automatic stop();
        phase(1'b0, 1'b0, 4);
        phase(1'b1, 1'b0, 4);
        phase(1'b1, 1'b1, 4);
    endtask
    // sampled mid-cycle so the device's drive has long settled
    task automatic bit_io(input logic b, output logic seen);
        phase(1'b0, b, 4);
        phase(1'b1, b, 3);
        @(negedge sys_clk_i);
        seen = sda_i;
        @(posedge sys_clk_i);
        phase(1'b0, b, 4);
    endtask
    task automatic xfer(input logic [7:0] tx, input logic ack_in,
                        output logic [7:0] rx, output logic ack_out);
        for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
        bit_io(ack_in, ack_out);
    endtask
endmodule

// ### verification/cgc_config_bank_bench.sv
`timescale 1ns/1ps
module cgc_config_bank_bench
    import cgc_pkg::*;
;
    localparam logic [3:0] REV  = 4'hA;  // arbitrary value
    localparam logic [3:0] VEN  = 4'hC;  // arbitrary value
    localparam logic [3:0] PART = 4'h9;  // arbitrary value
    logic        sys_clk_i     = 1'b0;
    logic        resetn_i      = 1'b0;
    logic        ce_i          = 1'b1;
    logic        powerdown_n_i = 1'b1;
    logic        sda_o;
    logic        sda_oe_n_o;
    logic        host_scl;
    logic        host_sda;
    cgc_ctrl_t   ctrl_o;
    wire logic   sda_line = host_sda & (sda_oe_n_o | sda_o);  // pulled-up wire
    int          n_mismatch    = 0;
    int          total_checks  = 0;
    logic [7:0]  rd;
    logic        ack;
    logic [7:0]  dflt [10] = '{8'hA1, 8'h85, 8'h3F, 8'hFF, 8'hED, 8'h00, 8'h00,
                               {REV, VEN}, {PART, 4'h0}, 8'h25};
    int          pos [4]   = '{6, 5, 2, 3};

    always #2.5 sys_clk_i = ~sys_clk_i;

    cgc_config_bank #(
        .REV_CODE(REV), .VENDOR_CODE(VEN), .PART_CODE(PART), .PROG_CODE(8'h3C)
    ) i_cgc_config_bank (
        .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .ce_i(ce_i), .scl_i(host_scl),
        .sda_i(sda_line), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o),
        .powerdown_n_i(powerdown_n_i), .ctrl_o(ctrl_o)
    );
    cgc_smb_host i_cgc_smb_host (
        .sys_clk_i(sys_clk_i), .sda_i(sda_line), .scl_o(host_scl), .sda_o(host_sda)
    );

    task automatic close_out();
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic send(input logic [7:0] b);
        i_cgc_smb_host.xfer(b, 1'b1, rd, ack);
        check("slave ack", ack, 1'b0);
    endtask
    task automatic wr(input logic [6:0] ofs, input logic [7:0] d);
        i_cgc_smb_host.start();
        send(8'hD2);
        send({1'b1, ofs});
        send(d);
        i_cgc_smb_host.stop();
    endtask
    task automatic rdb(input logic [6:0] ofs, input logic [7:0] exp);
        i_cgc_smb_host.start();
        send(8'hD2);
        send({1'b1, ofs});
        i_cgc_smb_host.start();
        send(8'hD3);
        i_cgc_smb_host.xfer(8'hFF, 1'b1, rd, ack);
        i_cgc_smb_host.stop();
        check("byte read", rd, exp);
    endtask
    task automatic blk(input logic rd_n, input logic [7:0] q [$]);
        i_cgc_smb_host.start();
        send(8'hD2);
        send(8'h00);
        if (rd_n) begin
            send(8'(q.size()));
            foreach (q[i]) send(q[i]);
        end else begin
            i_cgc_smb_host.start();
            send(8'hD3);
            foreach (q[i]) begin
                i_cgc_smb_host.xfer(8'hFF, i == q.size() - 1, rd, ack);
                check("block read", rd, q[i]);
            end
        end
        i_cgc_smb_host.stop();
    endtask
    task automatic pd_pulse();
        powerdown_n_i <= 1'b0;
        repeat (3) @(posedge sys_clk_i);
        powerdown_n_i <= 1'b1;
        repeat (3) @(posedge sys_clk_i);
    endtask

    // the sequence needs about 21500 cycles
    initial begin
        repeat (60000) @(posedge sys_clk_i);
        n_mismatch++;
        close_out();
    end

    initial begin
        logic [7:0]  v;
        logic [11:0] e;
        repeat (20) @(posedge sys_clk_i);
        resetn_i <= 1'b1;
        @(posedge sys_clk_i);
        check("ctrl reset", ctrl_o, 12'hF05);
        for (int i = 0; i < 10; i++) rdb(7'(i), dflt[i]);
        for (int a = 0; a < 8; a++) begin
            v = {3'b001, a[0], a[2], a[2:0]};  // reserved bits rewritten as read
            wr(7'h09, v);
            e = {4'hF, 2'b00, a[2], a[2] & ~a[0], a[2] & a[0], a[2:0]};
            check("test and amplitude", ctrl_o, e);
            rdb(7'h09, v);
        end
        wr(7'h09, 8'h25);
        for (int k = 0; k < 4; k++) begin
            v = 8'hED & ~(8'h01 << pos[k]) | {6'h00, k[0], 1'b0};
            wr(7'h04, v);
            e = {4'hF & ~(4'h1 << k), k[0], 7'h05};
            check("output enables", ctrl_o, e);
        end
        wr(7'h04, 8'hED);
        wr(7'h01, 8'hC5);
        check("center spread", ctrl_o, 12'hF45);
        wr(7'h01, 8'h85);
        check("down spread", ctrl_o, 12'hF05);
        wr(7'h07, 8'h00);
        wr(7'h08, 8'hFF);
        wr(7'h05, 8'hFF);
        wr(7'h00, 8'h5E);
        rdb(7'h07, dflt[7]);
        rdb(7'h08, dflt[8]);
        rdb(7'h05, 8'h00);
        rdb(7'h00, 8'hA0);
        wr(7'h09, 8'h22);
        ce_i <= 1'b0;
        pd_pulse();
        ce_i <= 1'b1;
        check("frozen while disabled", ctrl_o, 12'hF02);
        pd_pulse();
        check("cleared on power-down", ctrl_o, 12'hF05);
        rdb(7'h00, 8'hA1);
        wr(7'h09, 8'h22);
        pd_pulse();
        check("kept over power-down", ctrl_o, 12'hF02);
        rdb(7'h09, 8'h22);
        i_cgc_smb_host.start();
        i_cgc_smb_host.xfer(8'hD4, 1'b1, rd, ack);
        i_cgc_smb_host.stop();
        check("foreign address", ack, 1'b1);
        wr(7'h0C, 8'h03);
        blk(1'b0, '{8'h03, 8'hA1, 8'h85, 8'h3F, 8'hFF});
        blk(1'b1, '{8'hA1, 8'hC5, 8'h3F, 8'hFF, 8'hEF});
        check("block write", ctrl_o, 12'hFC2);
        close_out();
    end
endmodule
